// file: common/ilcd_pkg.sv
// shared constants for the instruction length and cycle decoder
// assumes one system clock and an opcode byte handed over by the fetch unit

package ilcd_pkg;

  // ==========================================================
  // widths and counts
  localparam int LEN_W = 2;
  localparam int CYC_W = 3;
  localparam int BANK_W = 2;
  localparam logic [1:0] LEN1 = 2'h1, LEN2 = 2'h2, LEN3 = 2'h3;
  localparam logic [2:0] CYC1 = 3'h1, CYC2 = 3'h2, CYC3 = 3'h3, CYC4 = 3'h4;
  localparam logic [2:0] CYC_ZERO = 3'h0;
  localparam logic [1:0] PTR_PAD = 2'h0;

  // ==========================================================
  // instruction classes
  typedef enum logic [3:0] {
    CLS_NONE, CLS_MOVE, CLS_CODE_READ, CLS_AUX_READ, CLS_AUX_WRITE,
    CLS_XCH, CLS_LOW_NIBBLE_EXCHANGE, CLS_ADD, CLS_ADD_WITH_CARRY, CLS_SUBTRACT_WITH_BORROW
  } ilcd_cls_t;

  // ==========================================================
  // opcodes with a working register in bits 2:0
  localparam logic [4:0] OP5_MOV_A_WREG = 5'h1D, OP5_MOV_WREG_A = 5'h1F, OP5_MOV_WREG_DIR = 5'h15;
  localparam logic [4:0] OP5_MOV_WREG_IMM = 5'h0F, OP5_MOV_DIR_WREG = 5'h11, OP5_XCH_WREG = 5'h19;
  localparam logic [4:0] OP5_ADD_WREG = 5'h05, OP5_ADD_WITH_CARRY_WREG = 5'h07, OP5_SUBTRACT_WITH_BORROW_WREG = 5'h13;

  // opcodes with a pointer register in bit 0
  localparam logic [6:0] OP7_MOV_A_IND = 7'h73, OP7_MOV_DIR_IND = 7'h43, OP7_MOV_IND_A = 7'h7B;
  localparam logic [6:0] OP7_MOV_IND_DIR = 7'h53, OP7_MOV_IND_IMM = 7'h3B, OP7_AUX_RD_IND = 7'h71;
  localparam logic [6:0] OP7_AUX_WR_IND = 7'h79, OP7_XCH_IND = 7'h63, OP7_LOW_NIBBLE_EXCHANGE_IND = 7'h6B;
  localparam logic [6:0] OP7_ADD_IND = 7'h13, OP7_ADD_WITH_CARRY_IND = 7'h1B, OP7_SUBTRACT_WITH_BORROW_IND = 7'h4B;

  // full-byte opcodes
  localparam logic [7:0] OP8_MOV_A_DIR = 8'hE5, OP8_MOV_A_IMM = 8'h74, OP8_MOV_DIR_A = 8'hF5;
  localparam logic [7:0] OP8_MOV_DIR_DIR = 8'h85, OP8_MOV_DIR_IMM = 8'h75, OP8_LOAD_DATA_POINTER = 8'h90;
  localparam logic [7:0] OP8_CODE_RD_DATA_POINTER = 8'h93, OP8_CODE_RD_PC = 8'h83, OP8_AUX_RD_DATA_POINTER = 8'hE0;
  localparam logic [7:0] OP8_AUX_WR_DATA_POINTER = 8'hF0, OP8_XCH_DIR = 8'hC5, OP8_ADD_DIR = 8'h25;
  localparam logic [7:0] OP8_ADD_IMM = 8'h24, OP8_ADD_WITH_CARRY_DIR = 8'h35, OP8_ADD_WITH_CARRY_IMM = 8'h34;
  localparam logic [7:0] OP8_SUBTRACT_WITH_BORROW_DIR = 8'h95, OP8_SUBTRACT_WITH_BORROW_IMM = 8'h94;

endpackage : ilcd_pkg

// file: design/ilcd_decode_table.sv
// opcode to length, cycle count and class lookup
// assumes a stable opcode byte; purely combinational
`timescale 1ns/1ps
`default_nettype none

module ilcd_decode_table (
  // opcode in
  input wire logic [7:0] opcode,
  // decoded shape
  output logic hit,
  output logic [1:0] len,
  output logic [2:0] cyc,
  output ilcd_pkg::ilcd_cls_t cls,
  output logic uses_wreg,
  output logic uses_ptr
);

  // ==========================================================
  // entry is class, length, cycles
  localparam logic [8:0] ENT_NONE = {ilcd_pkg::CLS_NONE, ilcd_pkg::LEN1, ilcd_pkg::CYC1};

  logic [8:0] ent5;
  logic [8:0] ent7;
  logic [8:0] ent8;
  wire [4:0] hi5 = opcode[7:3];
  wire [6:0] hi7 = opcode[7:1];
  wire hit5 = (ent5 != ENT_NONE);
  wire hit7 = (ent7 != ENT_NONE);
  wire [8:0] ent = hit5 ? ent5 : (hit7 ? ent7 : ent8);

  // ==========================================================
  // working register forms
  always_comb begin
    ent5 = ENT_NONE;
    if (hi5 == ilcd_pkg::OP5_MOV_A_WREG) ent5 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN1, ilcd_pkg::CYC1};
    else if (hi5 == ilcd_pkg::OP5_MOV_WREG_A) ent5 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN1, ilcd_pkg::CYC2};
    else if (hi5 == ilcd_pkg::OP5_MOV_WREG_DIR) ent5 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC4};
    else if (hi5 == ilcd_pkg::OP5_MOV_WREG_IMM) ent5 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
    else if (hi5 == ilcd_pkg::OP5_MOV_DIR_WREG) ent5 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (hi5 == ilcd_pkg::OP5_XCH_WREG) ent5 = {ilcd_pkg::CLS_XCH, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi5 == ilcd_pkg::OP5_ADD_WREG) ent5 = {ilcd_pkg::CLS_ADD, ilcd_pkg::LEN1, ilcd_pkg::CYC2};
    else if (hi5 == ilcd_pkg::OP5_ADD_WITH_CARRY_WREG) ent5 = {ilcd_pkg::CLS_ADD_WITH_CARRY, ilcd_pkg::LEN1, ilcd_pkg::CYC2};
    else if (hi5 == ilcd_pkg::OP5_SUBTRACT_WITH_BORROW_WREG) ent5 = {ilcd_pkg::CLS_SUBTRACT_WITH_BORROW, ilcd_pkg::LEN1, ilcd_pkg::CYC2};
  end

  // ==========================================================
  // pointer register forms
  always_comb begin
    ent7 = ENT_NONE;
    if (hi7 == ilcd_pkg::OP7_MOV_A_IND) ent7 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN1, ilcd_pkg::CYC2};
    else if (hi7 == ilcd_pkg::OP7_MOV_DIR_IND) ent7 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC4};
    else if (hi7 == ilcd_pkg::OP7_MOV_IND_A) ent7 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_MOV_IND_DIR) ent7 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_MOV_IND_IMM) ent7 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_AUX_RD_IND) ent7 = {ilcd_pkg::CLS_AUX_READ, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_AUX_WR_IND) ent7 = {ilcd_pkg::CLS_AUX_WRITE, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_XCH_IND) ent7 = {ilcd_pkg::CLS_XCH, ilcd_pkg::LEN1, ilcd_pkg::CYC4};
    else if (hi7 == ilcd_pkg::OP7_LOW_NIBBLE_EXCHANGE_IND) ent7 = {ilcd_pkg::CLS_LOW_NIBBLE_EXCHANGE, ilcd_pkg::LEN1, ilcd_pkg::CYC4};
    else if (hi7 == ilcd_pkg::OP7_ADD_IND) ent7 = {ilcd_pkg::CLS_ADD, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_ADD_WITH_CARRY_IND) ent7 = {ilcd_pkg::CLS_ADD_WITH_CARRY, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (hi7 == ilcd_pkg::OP7_SUBTRACT_WITH_BORROW_IND) ent7 = {ilcd_pkg::CLS_SUBTRACT_WITH_BORROW, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
  end

  // ==========================================================
  // full-byte forms
  always_comb begin
    ent8 = ENT_NONE;
    if (opcode == ilcd_pkg::OP8_MOV_A_DIR) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
    else if (opcode == ilcd_pkg::OP8_MOV_A_IMM) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
    else if (opcode == ilcd_pkg::OP8_MOV_DIR_A) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_MOV_DIR_DIR) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN3, ilcd_pkg::CYC4};
    else if (opcode == ilcd_pkg::OP8_MOV_DIR_IMM) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN3, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_LOAD_DATA_POINTER) ent8 = {ilcd_pkg::CLS_MOVE, ilcd_pkg::LEN3, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_CODE_RD_DATA_POINTER) ent8 = {ilcd_pkg::CLS_CODE_READ, ilcd_pkg::LEN1, ilcd_pkg::CYC4};
    else if (opcode == ilcd_pkg::OP8_CODE_RD_PC) ent8 = {ilcd_pkg::CLS_CODE_READ, ilcd_pkg::LEN1, ilcd_pkg::CYC4};
    else if (opcode == ilcd_pkg::OP8_AUX_RD_DATA_POINTER) ent8 = {ilcd_pkg::CLS_AUX_READ, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_AUX_WR_DATA_POINTER) ent8 = {ilcd_pkg::CLS_AUX_WRITE, ilcd_pkg::LEN1, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_XCH_DIR) ent8 = {ilcd_pkg::CLS_XCH, ilcd_pkg::LEN2, ilcd_pkg::CYC4};
    else if (opcode == ilcd_pkg::OP8_ADD_DIR) ent8 = {ilcd_pkg::CLS_ADD, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_ADD_IMM) ent8 = {ilcd_pkg::CLS_ADD, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
    else if (opcode == ilcd_pkg::OP8_ADD_WITH_CARRY_DIR) ent8 = {ilcd_pkg::CLS_ADD_WITH_CARRY, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_ADD_WITH_CARRY_IMM) ent8 = {ilcd_pkg::CLS_ADD_WITH_CARRY, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
    else if (opcode == ilcd_pkg::OP8_SUBTRACT_WITH_BORROW_DIR) ent8 = {ilcd_pkg::CLS_SUBTRACT_WITH_BORROW, ilcd_pkg::LEN2, ilcd_pkg::CYC3};
    else if (opcode == ilcd_pkg::OP8_SUBTRACT_WITH_BORROW_IMM) ent8 = {ilcd_pkg::CLS_SUBTRACT_WITH_BORROW, ilcd_pkg::LEN2, ilcd_pkg::CYC2};
  end

  // ==========================================================
  // outputs
  assign cls = ilcd_pkg::ilcd_cls_t'(ent[8:5]);
  assign len = ent[4:3];
  assign cyc = ent[2:0];
  assign hit = (cls != ilcd_pkg::CLS_NONE);
  assign uses_wreg = hit5;
  assign uses_ptr = hit7;

endmodule : ilcd_decode_table
`default_nettype wire

// file: design/ilcd_cycle_hold.sv
// holds the fetch handshake for the decoded number of cycles
// assumes start only while ready is high, same clock as the fetch unit
`timescale 1ns/1ps
`default_nettype none

module ilcd_cycle_hold (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // instruction start
  input wire logic start,
  input wire logic [2:0] cycles,
  // fetch handshake
  output logic ready_ff
);

  // ==========================================================
  // remaining cycles after the current one
  logic [2:0] rem_ff;
  wire [2:0] nxt_rem = start ? (cycles - ilcd_pkg::CYC1) :
                       ((rem_ff != ilcd_pkg::CYC_ZERO) ? (rem_ff - ilcd_pkg::CYC1) : ilcd_pkg::CYC_ZERO);
  // single-cycle ops keep ready high so fetch can stream back to back
  wire nxt_ready = start ? (cycles == ilcd_pkg::CYC1) : (rem_ff <= ilcd_pkg::CYC1);

  always_ff @(posedge clock) begin
    if (srst) begin
      rem_ff <= ilcd_pkg::CYC_ZERO;
      ready_ff <= 1'b1;
    end else begin
      rem_ff <= nxt_rem;
      ready_ff <= nxt_ready;
    end
  end

endmodule : ilcd_cycle_hold
`default_nettype wire

// file: design/ilcd_decoder.sv
// instruction length and cycle decoder for data transfer and arithmetic ops
// assumes the fetch unit offers one opcode byte at a time on the system clock,
// and the datapath consumes the registered decode the cycle after acceptance
`timescale 1ns/1ps
`default_nettype none

module ilcd_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // fetch side
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  output logic fetch_ready,
  // core context
  input wire logic [1:0] reg_bank,
  input wire logic aux_ext_select,
  // decode result
  output logic dec_valid,
  output logic dec_hit,
  output logic [1:0] instr_len,
  output logic [2:0] exec_cycles,
  output ilcd_pkg::ilcd_cls_t instr_class,
  // operand selection
  output logic uses_wreg,
  output logic [4:0] wreg_sel,
  output logic uses_ptr,
  output logic [4:0] ptr_sel,
  // aux ram routing
  output logic aux_onchip_sel,
  output logic aux_ext_refused
);

  // ==========================================================
  // table lookup
  logic tbl_hit;
  logic [1:0] tbl_len;
  logic [2:0] tbl_cyc;
  ilcd_pkg::ilcd_cls_t tbl_cls;
  logic tbl_uses_wreg;
  logic tbl_uses_ptr;

  ilcd_decode_table u_table (
    .opcode(op_byte),
    .hit(tbl_hit),
    .len(tbl_len),
    .cyc(tbl_cyc),
    .cls(tbl_cls),
    .uses_wreg(tbl_uses_wreg),
    .uses_ptr(tbl_uses_ptr)
  );

  // ==========================================================
  // acceptance and hold
  logic ready_ff;
  wire accept = op_valid && ready_ff;

  ilcd_cycle_hold u_hold (
    .clock(clock),
    .srst(srst),
    .start(accept),
    .cycles(tbl_cyc),
    .ready_ff(ready_ff)
  );

  // ==========================================================
  // next-value selection
  wire tbl_aux = (tbl_cls == ilcd_pkg::CLS_AUX_READ) || (tbl_cls == ilcd_pkg::CLS_AUX_WRITE);
  wire [4:0] nxt_wreg_sel = {reg_bank, op_byte[2:0]};
  wire [4:0] nxt_ptr_sel = {reg_bank, ilcd_pkg::PTR_PAD, op_byte[0]};
  // external aux targets are never served; route on-chip and flag it
  wire nxt_refused = tbl_aux && aux_ext_select;

  // ==========================================================
  // result registers, held until the next accepted opcode, except dec_valid and aux_ext_refused, which pulse for one cycle
  logic dec_valid_ff;
  logic dec_hit_ff;
  logic [1:0] instr_len_ff;
  logic [2:0] exec_cycles_ff;
  ilcd_pkg::ilcd_cls_t instr_class_ff;
  logic uses_wreg_ff;
  logic [4:0] wreg_sel_ff;
  logic uses_ptr_ff;
  logic [4:0] ptr_sel_ff;
  logic aux_onchip_sel_ff;
  logic aux_ext_refused_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      dec_valid_ff <= 1'b0;
      aux_ext_refused_ff <= 1'b0;
    end else begin
      dec_valid_ff <= accept;
      aux_ext_refused_ff <= accept && nxt_refused;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dec_hit_ff <= 1'b0;
      instr_len_ff <= ilcd_pkg::LEN1;
      exec_cycles_ff <= ilcd_pkg::CYC1;
      instr_class_ff <= ilcd_pkg::CLS_NONE;
    end else if (accept) begin
      dec_hit_ff <= tbl_hit;
      instr_len_ff <= tbl_len;
      exec_cycles_ff <= tbl_cyc;
      instr_class_ff <= tbl_cls;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      uses_wreg_ff <= 1'b0;
      wreg_sel_ff <= 5'h00;
      uses_ptr_ff <= 1'b0;
      ptr_sel_ff <= 5'h00;
      aux_onchip_sel_ff <= 1'b0;
    end else if (accept) begin
      uses_wreg_ff <= tbl_uses_wreg;
      wreg_sel_ff <= nxt_wreg_sel;
      uses_ptr_ff <= tbl_uses_ptr;
      ptr_sel_ff <= nxt_ptr_sel;
      aux_onchip_sel_ff <= tbl_aux;
    end
  end

  // ==========================================================
  // output drive
  assign fetch_ready = ready_ff;
  assign dec_valid = dec_valid_ff;
  assign dec_hit = dec_hit_ff;
  assign instr_len = instr_len_ff;
  assign exec_cycles = exec_cycles_ff;
  assign instr_class = instr_class_ff;
  assign uses_wreg = uses_wreg_ff;
  assign wreg_sel = wreg_sel_ff;
  assign uses_ptr = uses_ptr_ff;
  assign ptr_sel = ptr_sel_ff;
  assign aux_onchip_sel = aux_onchip_sel_ff;
  assign aux_ext_refused = aux_ext_refused_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  wire [4:0] op_hi5 = op_byte[7:3];
  wire [6:0] op_hi7 = op_byte[7:1];

  property p_shape(logic m, logic [1:0] l, logic [2:0] c);
    accept && m |=> dec_valid && dec_hit && instr_len == l && exec_cycles == c;
  endproperty

  AST_RL1_REG_TO_ACC:
    assert property (accept && op_hi5 == ilcd_pkg::OP5_MOV_A_WREG
      |=> instr_len == ilcd_pkg::LEN1 && exec_cycles == ilcd_pkg::CYC1 && fetch_ready)
    else $error("register to accumulator not one byte one cycle");

  AST_RL2_DIR_TO_ACC:
    assert property (accept && op_byte == ilcd_pkg::OP8_MOV_A_DIR
      |=> instr_len == ilcd_pkg::LEN2 && !fetch_ready ##1 fetch_ready)
    else $error("direct to accumulator shape wrong");

  AST_RL3_IND_TO_ACC:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_MOV_A_IND, ilcd_pkg::LEN1, ilcd_pkg::CYC2))
    else $error("indirect to accumulator shape wrong");

  AST_RL4_IMM_TO_ACC:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_MOV_A_IMM, ilcd_pkg::LEN2, ilcd_pkg::CYC2))
    else $error("immediate to accumulator shape wrong");

  AST_RL5_ACC_TO_REG:
    assert property (p_shape(op_hi5 == ilcd_pkg::OP5_MOV_WREG_A, ilcd_pkg::LEN1, ilcd_pkg::CYC2))
    else $error("accumulator to register shape wrong");

  AST_RL6_DIR_TO_REG:
    assert property (accept && op_hi5 == ilcd_pkg::OP5_MOV_WREG_DIR
      |=> instr_len == ilcd_pkg::LEN2 && !fetch_ready [*3] ##1 fetch_ready)
    else $error("direct to register not held four cycles");

  AST_RL7_IMM_TO_REG:
    assert property (p_shape(op_hi5 == ilcd_pkg::OP5_MOV_WREG_IMM, ilcd_pkg::LEN2, ilcd_pkg::CYC2))
    else $error("immediate to register shape wrong");

  AST_RL8_STORE_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_MOV_DIR_A || op_hi5 == ilcd_pkg::OP5_MOV_DIR_WREG,
      ilcd_pkg::LEN2, ilcd_pkg::CYC3))
    else $error("store to direct shape wrong");

  AST_RL9_DIR_TO_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_MOV_DIR_DIR, ilcd_pkg::LEN3, ilcd_pkg::CYC4))
    else $error("direct to direct shape wrong");

  AST_RL10_IND_TO_DIR:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_MOV_DIR_IND, ilcd_pkg::LEN2, ilcd_pkg::CYC4))
    else $error("indirect to direct shape wrong");

  AST_RL11_IMM_TO_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_MOV_DIR_IMM, ilcd_pkg::LEN3, ilcd_pkg::CYC3))
    else $error("immediate to direct shape wrong");

  AST_RL12_STORE_IND:
    assert property (accept && (op_hi7 == ilcd_pkg::OP7_MOV_IND_DIR || op_hi7 == ilcd_pkg::OP7_MOV_IND_IMM)
      |=> instr_len == ilcd_pkg::LEN2 && exec_cycles == ilcd_pkg::CYC3 && uses_ptr)
    else $error("store to indirect shape wrong");

  AST_RL13_LOAD_POINTER:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_LOAD_DATA_POINTER, ilcd_pkg::LEN3, ilcd_pkg::CYC3))
    else $error("data pointer load shape wrong");

  AST_RL14_CODE_READ:
    assert property (accept && (op_byte == ilcd_pkg::OP8_CODE_RD_DATA_POINTER || op_byte == ilcd_pkg::OP8_CODE_RD_PC)
      |=> instr_class == ilcd_pkg::CLS_CODE_READ && instr_len == ilcd_pkg::LEN1
      && exec_cycles == ilcd_pkg::CYC4)
    else $error("code memory read shape wrong");

  AST_RL15_AUX_MOVE:
    assert property (accept && (tbl_cls == ilcd_pkg::CLS_AUX_READ || tbl_cls == ilcd_pkg::CLS_AUX_WRITE)
      |=> instr_len == ilcd_pkg::LEN1 && !fetch_ready [*2] ##1 fetch_ready)
    else $error("aux ram move not one byte three cycles");

  AST_RL16_ONCHIP_ONLY:
    assert property (accept && tbl_aux
      |=> aux_onchip_sel && dec_valid && aux_ext_refused == $past(aux_ext_select))
    else $error("aux move not kept on chip");

  AST_RL16_NO_STRAY_REFUSE:
    assert property (aux_ext_refused |-> dec_valid && aux_onchip_sel)
    else $error("refusal flagged without aux move");

  AST_RL17_EXCHANGE:
    assert property (p_shape(op_hi5 == ilcd_pkg::OP5_XCH_WREG, ilcd_pkg::LEN1, ilcd_pkg::CYC3))
    else $error("register exchange shape wrong");

  AST_RL18_NIBBLE_EXCHANGE:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_LOW_NIBBLE_EXCHANGE_IND, ilcd_pkg::LEN1, ilcd_pkg::CYC4))
    else $error("low nibble exchange shape wrong");

  AST_RL19_ADD_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_ADD_DIR, ilcd_pkg::LEN2, ilcd_pkg::CYC3))
    else $error("add direct shape wrong");

  AST_RL20_ADD_WITH_CARRY_IMM:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_ADD_WITH_CARRY_IMM, ilcd_pkg::LEN2, ilcd_pkg::CYC2))
    else $error("add with carry immediate shape wrong");

  AST_RL21_SUBTRACT_WITH_BORROW_IND:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_SUBTRACT_WITH_BORROW_IND, ilcd_pkg::LEN1, ilcd_pkg::CYC3))
    else $error("subtract indirect shape wrong");

  AST_RL22_SUBTRACT_WITH_BORROW_IMM:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_SUBTRACT_WITH_BORROW_IMM, ilcd_pkg::LEN2, ilcd_pkg::CYC2))
    else $error("subtract immediate shape wrong");

  AST_RL23_HOLD_THREE:
    assert property (accept && tbl_cyc == ilcd_pkg::CYC3 |=> !fetch_ready [*2] ##1 fetch_ready)
    else $error("three cycle op not held exactly");

  AST_RL23_ONE_STREAMS:
    assert property (accept && tbl_cyc == ilcd_pkg::CYC1 |=> fetch_ready)
    else $error("one cycle op stalled fetch");

  AST_RL24_BANK_SELECT:
    assert property (accept && tbl_uses_wreg
      |=> uses_wreg && wreg_sel[4:3] == $past(reg_bank) && wreg_sel[2:0] == $past(op_byte[2:0]))
    else $error("working register bank select wrong");

  AST_RL24_POINTER_SELECT:
    assert property (accept && tbl_uses_ptr
      |=> uses_ptr && ptr_sel == {$past(reg_bank), ilcd_pkg::PTR_PAD, $past(op_byte[0])})
    else $error("pointer register select wrong");

  AST_RL12_STORE_ACC_IND:
    assert property (accept && op_hi7 == ilcd_pkg::OP7_MOV_IND_A
      |=> instr_len == ilcd_pkg::LEN1 && exec_cycles == ilcd_pkg::CYC3 && uses_ptr)
    else $error("accumulator to indirect shape wrong");

  AST_RL14_CODE_HOLD:
    assert property (accept && tbl_cls == ilcd_pkg::CLS_CODE_READ |=> !fetch_ready [*3] ##1 fetch_ready)
    else $error("code memory read not held four cycles");

  AST_RL16_PLAIN_NOT_AUX:
    assert property (accept && !tbl_aux |=> !aux_onchip_sel && !aux_ext_refused)
    else $error("aux routing flagged on a plain op");

  AST_RL17_EXCH_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_XCH_DIR, ilcd_pkg::LEN2, ilcd_pkg::CYC4))
    else $error("direct exchange shape wrong");

  AST_RL17_EXCH_IND:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_XCH_IND, ilcd_pkg::LEN1, ilcd_pkg::CYC4))
    else $error("indirect exchange shape wrong");

  AST_RL19_ADD_REG:
    assert property (p_shape(op_hi5 == ilcd_pkg::OP5_ADD_WREG, ilcd_pkg::LEN1, ilcd_pkg::CYC2))
    else $error("add register shape wrong");

  AST_RL19_ADD_IND:
    assert property (p_shape(op_hi7 == ilcd_pkg::OP7_ADD_IND, ilcd_pkg::LEN1, ilcd_pkg::CYC3))
    else $error("add indirect shape wrong");

  AST_RL20_ADD_WITH_CARRY_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_ADD_WITH_CARRY_DIR, ilcd_pkg::LEN2, ilcd_pkg::CYC3))
    else $error("add with carry direct shape wrong");

  AST_RL21_SUBTRACT_WITH_BORROW_REG:
    assert property (p_shape(op_hi5 == ilcd_pkg::OP5_SUBTRACT_WITH_BORROW_WREG, ilcd_pkg::LEN1, ilcd_pkg::CYC2))
    else $error("subtract register shape wrong");

  AST_RL21_SUBTRACT_WITH_BORROW_DIR:
    assert property (p_shape(op_byte == ilcd_pkg::OP8_SUBTRACT_WITH_BORROW_DIR, ilcd_pkg::LEN2, ilcd_pkg::CYC3))
    else $error("subtract direct shape wrong");

  AST_RL23_HOLD_TWO:
    assert property (accept && tbl_cyc == ilcd_pkg::CYC2 |=> !fetch_ready ##1 fetch_ready)
    else $error("two cycle op not held exactly");

  AST_RL23_VALID_PULSE:
    assert property (dec_valid == $past(accept))
    else $error("decode valid not one cycle after accept");

  COV_UNKNOWN_OP: cover property (accept && !tbl_hit);
  COV_BACK_TO_BACK: cover property (accept && tbl_cyc == ilcd_pkg::CYC1 ##1 accept);
  COV_FOUR_CYCLE: cover property (accept && tbl_cyc == ilcd_pkg::CYC4 ##4 accept);
  COV_AUX_REFUSED: cover property (aux_ext_refused);
  COV_DIR_TO_DIR: cover property (accept && op_byte == ilcd_pkg::OP8_MOV_DIR_DIR);

endmodule : ilcd_decoder
`default_nettype wire

// file: dv/ilcd_fetch_model.sv
// fetch unit model: offers opcode bytes, holds each one until taken
// assumes calls just after a falling edge of clock
`timescale 1ns/1ps
`default_nettype none
module ilcd_fetch_model (
  // clock
  input wire logic clock,
  // fetch side
  output logic op_valid,
  output logic [7:0] op_byte,
  input wire logic fetch_ready
);
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
  end
  // ready is read before the edge so the decision never races the edge
  task automatic send(input logic [7:0] b);
    logic ok;
    op_valid = 1'b1;
    op_byte = b;
    do begin
      ok = fetch_ready;
      @(posedge clock);
      if (ok !== 1'b1) @(negedge clock);
    end while (ok !== 1'b1);
  endtask : send
  // released lines show the inverse so a stale byte never matches
  task automatic release_bus();
    op_valid = 1'b0;
    op_byte = ~op_byte;
  endtask : release_bus
endmodule : ilcd_fetch_model
`default_nettype wire

// file: dv/tb_top.sv
// decoder bench: fetch model feeds opcodes back to back, monitor checks
// assumes ilcd_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, srst, op_valid, fetch_ready, aux_ext_select, dec_valid, dec_hit;
  logic uses_wreg, uses_ptr, aux_onchip_sel, aux_ext_refused;
  logic [7:0] op_byte;
  logic [1:0] reg_bank, instr_len;
  logic [2:0] exec_cycles, last_cyc;
  logic [4:0] wreg_sel, ptr_sel;
  ilcd_pkg::ilcd_cls_t instr_class;
  logic [23:0] exp_q[$];
  logic [23:0] e, s;
  int errors, total_checks, seed, gap;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ilcd_fetch_model fm (.clock(clock), .op_valid(op_valid), .op_byte(op_byte), .fetch_ready(fetch_ready));
  ilcd_decoder dut (.clock(clock), .srst(srst), .op_valid(op_valid), .op_byte(op_byte), .fetch_ready(fetch_ready),
    .reg_bank(reg_bank), .aux_ext_select(aux_ext_select), .dec_valid(dec_valid), .dec_hit(dec_hit),
    .instr_len(instr_len), .exec_cycles(exec_cycles), .instr_class(instr_class), .uses_wreg(uses_wreg),
    .wreg_sel(wreg_sel), .uses_ptr(uses_ptr), .ptr_sel(ptr_sel), .aux_onchip_sel(aux_onchip_sel),
    .aux_ext_refused(aux_ext_refused));
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // k: 0 plain, 1 working register, 2 pointer, 3 not decoded here
  task automatic g(input logic [7:0] op, input int l, c, k, a, input ilcd_pkg::ilcd_cls_t cl);
    logic [7:0] o;
    @(negedge clock);
    reg_bank = 2'($random(seed));
    aux_ext_select = 1'($random(seed));
    o = op | (k == 1 ? 8'($random(seed)) & 8'h07 : k == 2 ? 8'($random(seed)) & 8'h01 : 8'h00);
    exp_q.push_back({cl, 2'(k), last_cyc, k != 3, 2'(l), 3'(c), aux_ext_select & a[0], a[0],
      k == 1 ? {reg_bank, o[2:0]} : k == 2 ? {reg_bank, 2'h0, o[0]} : 5'h00, k == 1, k == 2});
    last_cyc = 3'(c);
    fm.send(o);
  endtask : g
  // gap between decodes shows how long fetch was held
  always @(negedge clock) begin
    gap = gap + 1;
    if (dec_valid === 1'b1) begin
      e = exp_q.pop_front();
      s = {instr_class, e[19:18], e[17:15] == 3'h0 ? 3'h0 : 3'(gap), dec_hit, instr_len, exec_cycles,
        aux_ext_refused, aux_onchip_sel, e[19:18] == 2'h1 ? wreg_sel : e[19:18] == 2'h2 ? ptr_sel : 5'h00,
        uses_wreg, uses_ptr};
      check(s, e);
      gap = 0;
    end
  end
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    reg_bank = 2'h0;
    aux_ext_select = 1'b0;
    last_cyc = 3'h0;
    seed = 61245;
    repeat (4) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    check({16'h0, fetch_ready, dec_valid, dec_hit, instr_len, exec_cycles}, 24'h000089);
    g(8'hE8, 1, 1, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'hE8, 1, 1, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'hE5, 2, 2, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'hE6, 1, 2, 2, 0, ilcd_pkg::CLS_MOVE);
    g(8'h74, 2, 2, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'hF8, 1, 2, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'hA8, 2, 4, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'h78, 2, 2, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'hF5, 2, 3, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'h88, 2, 3, 1, 0, ilcd_pkg::CLS_MOVE);
    g(8'h85, 3, 4, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'h86, 2, 4, 2, 0, ilcd_pkg::CLS_MOVE);
    g(8'h75, 3, 3, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'hF6, 1, 3, 2, 0, ilcd_pkg::CLS_MOVE);
    g(8'hA6, 2, 3, 2, 0, ilcd_pkg::CLS_MOVE);
    g(8'h76, 2, 3, 2, 0, ilcd_pkg::CLS_MOVE);
    g(8'h90, 3, 3, 0, 0, ilcd_pkg::CLS_MOVE);
    g(8'h93, 1, 4, 0, 0, ilcd_pkg::CLS_CODE_READ);
    g(8'h83, 1, 4, 0, 0, ilcd_pkg::CLS_CODE_READ);
    repeat (3) begin
      g(8'hE2, 1, 3, 2, 1, ilcd_pkg::CLS_AUX_READ);
      g(8'hF2, 1, 3, 2, 1, ilcd_pkg::CLS_AUX_WRITE);
      g(8'hE0, 1, 3, 0, 1, ilcd_pkg::CLS_AUX_READ);
      g(8'hF0, 1, 3, 0, 1, ilcd_pkg::CLS_AUX_WRITE);
    end
    g(8'hC8, 1, 3, 1, 0, ilcd_pkg::CLS_XCH);
    g(8'hC5, 2, 4, 0, 0, ilcd_pkg::CLS_XCH);
    g(8'hC6, 1, 4, 2, 0, ilcd_pkg::CLS_XCH);
    g(8'hD6, 1, 4, 2, 0, ilcd_pkg::CLS_LOW_NIBBLE_EXCHANGE);
    g(8'h28, 1, 2, 1, 0, ilcd_pkg::CLS_ADD);
    g(8'h25, 2, 3, 0, 0, ilcd_pkg::CLS_ADD);
    g(8'h26, 1, 3, 2, 0, ilcd_pkg::CLS_ADD);
    g(8'h24, 2, 2, 0, 0, ilcd_pkg::CLS_ADD);
    g(8'h38, 1, 2, 1, 0, ilcd_pkg::CLS_ADD_WITH_CARRY);
    g(8'h35, 2, 3, 0, 0, ilcd_pkg::CLS_ADD_WITH_CARRY);
    g(8'h36, 1, 3, 2, 0, ilcd_pkg::CLS_ADD_WITH_CARRY);
    g(8'h34, 2, 2, 0, 0, ilcd_pkg::CLS_ADD_WITH_CARRY);
    g(8'h98, 1, 2, 1, 0, ilcd_pkg::CLS_SUBTRACT_WITH_BORROW);
    g(8'h95, 2, 3, 0, 0, ilcd_pkg::CLS_SUBTRACT_WITH_BORROW);
    g(8'h96, 1, 3, 2, 0, ilcd_pkg::CLS_SUBTRACT_WITH_BORROW);
    g(8'h94, 2, 2, 0, 0, ilcd_pkg::CLS_SUBTRACT_WITH_BORROW);
    g(8'hA5, 1, 1, 3, 0, ilcd_pkg::CLS_NONE);
    @(negedge clock);
    fm.release_bus();
    repeat (6) @(negedge clock);
    check(24'(exp_q.size()), 24'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
